// [rtl/dacc_top.sv]
// two-wire slave control of a dual 10-bit converter, with APB status/control
//
// Operation
// - address LSB follows the address-select pin
// - write loads output register or staging only
// - both registers hold while powered
// - channel codes are unsigned ten-bit binary
// - reset clears outputs and powers down
// - after reset outputs terminated with 100k
// - power-down disables buffers and reference strings
// - two-bit code selects power and termination
// - power-down keeps data, wake restores output
// - slave only; master clocks and starts
// - eight-bit words plus one acknowledge pulse
// - idle bus lines released, both high
// - start is SDA fall, stop SDA rise, SCL high
// - repeated start keeps the session active
// - ignore clock after stop or mismatch until start
// - data line driven low only, open drain
// - supports bus clocks up to 400 kHz
// - eighth bit of the address byte selects write or read
// - registers update at acknowledge falling edge
// - aborted write leaves registers unchanged
// - general call address is ignored
`timescale 1ns/100ps
module dacc_top
   import dacc_pkg::*;
#(
   parameter logic [5:0] ADDR_HI = 6'h15 // arbitrary upper address bits
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [DACC_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // two-wire bus and address strap
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic addr_sel,
   // converter channels
   output dacc_chan_s channel_a_output,
   output dacc_chan_s channel_b_output
);
   // ----------------------------------------
   // pin synchronisation and edge detection
   // ----------------------------------------
   logic [2:0] pin_s;
   logic scl_d, sda_d;

   dacc_sync #(.W(3)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({addr_sel, scl_i, sda_i}),
      .q(pin_s)
   );

   wire addr_lsb = pin_s[2];
   wire scl_s = pin_s[1];
   wire sda_s = pin_s[0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_d <= 1'b0;
         sda_d <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // 100 MHz oversampling leaves >100 samples per 400 kHz bit
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------
   // serial slave state
   // ----------------------------------------
   dacc_state_e state, next_state;
   logic [3:0] bit_cnt, next_cnt;
   logic [7:0] shift, next_shift;
   logic [7:0] cmd, next_cmd;
   logic [7:0] tx, next_tx;
   logic rw, next_rw;
   logic byte_idx, next_byte;
   logic rd_nack, next_nack;
   logic sda_drv, next_drv;
   logic bus_en;
   logic commit;

   wire [6:0] own_addr = {ADDR_HI, addr_lsb};
   wire exp_bit = own_addr[3'h6 - bit_cnt[2:0]];
   wire gen_call = (bit_cnt == BIT_A0) && (shift[5:0] == 6'h00) && !sda_s;
   wire sel_b = cmd[4];
   wire dacc_chan_s rd_ch = sel_b ? channel_b_output : channel_a_output;
   wire [15:0] rd_word = {rd_ch.pd, 2'h0, rd_ch.code, 2'h0};

   always_comb begin
      next_state = state;
      next_cnt = bit_cnt;
      next_shift = shift;
      next_cmd = cmd;
      next_tx = tx;
      next_rw = rw;
      next_byte = byte_idx;
      next_nack = rd_nack;
      next_drv = sda_drv;
      commit = 1'b0;
      if (stop_cond) begin
         next_state = ST_IDLE;
         next_drv = 1'b0;
         next_byte = 1'b0;
      end else if (start_cond) begin
         next_state = ST_ADDR;
         next_cnt = 4'h0;
         next_drv = 1'b0;
         next_byte = 1'b0;
      end else begin
         case (state)
            ST_ADDR: begin
               if (scl_rise) begin
                  next_shift = {shift[6:0], sda_s};
                  next_cnt = bit_cnt + 4'h1;
                  if (bit_cnt < BIT_RW && sda_s != exp_bit) next_state = ST_IDLE;
                  if (gen_call || (bit_cnt == BIT_A0 && !bus_en)) next_state = ST_IDLE;
                  if (bit_cnt == BIT_RW) next_rw = sda_s;
               end else if (scl_fall && bit_cnt == BIT_ACK) begin
                  next_drv = 1'b1;
                  next_state = ST_ACK_ADDR;
               end
            end
            ST_ACK_ADDR: begin
               if (scl_fall) begin
                  next_cnt = 4'h0;
                  next_byte = 1'b0;
                  if (rw) begin
                     next_tx = rd_word[15:8];
                     next_drv = ~rd_word[15];
                     next_state = ST_RD;
                  end else begin
                     next_drv = 1'b0;
                     next_state = ST_WR;
                  end
               end
            end
            ST_WR: begin
               if (scl_rise) begin
                  next_shift = {shift[6:0], sda_s};
                  next_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == BIT_ACK) begin
                  next_drv = 1'b1;
                  next_state = ST_ACK_WR;
               end
            end
            ST_ACK_WR: begin
               if (scl_fall) begin
                  next_drv = 1'b0;
                  next_cnt = 4'h0;
                  next_state = ST_WR;
                  next_byte = ~byte_idx;
                  if (!byte_idx) next_cmd = shift;
                  else commit = 1'b1;
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  if (bit_cnt == BIT_LAST) begin
                     next_drv = 1'b0;
                     next_state = ST_RD_ACK;
                  end else begin
                     next_tx = {tx[6:0], 1'b0};
                     next_drv = ~tx[6];
                     next_cnt = bit_cnt + 4'h1;
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  next_nack = sda_s;
               end else if (scl_fall) begin
                  if (rd_nack) begin
                     next_state = ST_IDLE;
                  end else begin
                     next_tx = byte_idx ? rd_word[15:8] : rd_word[7:0];
                     next_drv = byte_idx ? ~rd_word[15] : ~rd_word[7];
                     next_byte = ~byte_idx;
                     next_cnt = 4'h0;
                     next_state = ST_RD;
                  end
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         cmd <= 8'h00;
         tx <= 8'h00;
         rw <= 1'b0;
         byte_idx <= 1'b0;
         rd_nack <= 1'b0;
         sda_drv <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_cnt;
         shift <= next_shift;
         cmd <= next_cmd;
         tx <= next_tx;
         rw <= next_rw;
         byte_idx <= next_byte;
         rd_nack <= next_nack;
         sda_drv <= next_drv;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe = sda_drv;

   // ----------------------------------------
   // command decode and channel registers
   // ----------------------------------------
   function automatic logic cmd_load(input logic [7:0] c);
      return (c[7] == 1'b0) && (c[5] == 1'b0);
   endfunction

   function automatic logic cmd_direct(input logic [7:0] c);
      return cmd_load(c) && (c[6] == 1'b0);
   endfunction

   wire is_ext = (cmd == CMD_EXT);
   dacc_wr_s wr [2];
   dacc_chan_s chan [2];

   for (genvar i = 0; i < 2; i++) begin : g_chan
      assign wr[i] = '{stage_we: commit && !is_ext && cmd_load(cmd) && (sel_b == 1'(i)),
                       out_we: commit && !is_ext && cmd_direct(cmd),
                       pd_we: commit && is_ext && shift[2+i],
                       data: {cmd[3:0], shift[7:2]},
                       pd: shift[1:0]};
      dacc_chan u_chan (
         .clk(pclk),
         .rst_n(presetn),
         .wr(wr[i]),
         .chan(chan[i])
      );
   end

   assign channel_a_output = chan[0];
   assign channel_b_output = chan[1];

   // ----------------------------------------
   // apb registers
   // ----------------------------------------
   wire hit_ctrl = (paddr == OFS_CTRL);
   wire hit_a = (paddr == OFS_CHAN_A);
   wire hit_b = (paddr == OFS_CHAN_B);
   wire hit_stat = (paddr == OFS_STATUS);
   wire mapped = hit_ctrl | hit_a | hit_b | hit_stat;
   wire ctrl_we = psel & penable & pwrite & hit_ctrl;
   wire [31:0] next_prdata = hit_ctrl ? {31'h0, bus_en}
                           : hit_a ? {20'h0, chan[0].pd, chan[0].code}
                           : hit_b ? {20'h0, chan[1].pd, chan[1].code}
                           : hit_stat ? {29'h0, sda_drv, addr_lsb, state != ST_IDLE}
                           : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_en <= CTRL_BUS_EN_RESET;
         prdata <= 32'h0;
      end else begin
         if (ctrl_we) bus_en <= pwdata[0];
         if (psel && !penable) prdata <= next_prdata;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_bad_bit;
      state == ST_ADDR && scl_rise && !start_cond && !stop_cond
         && bit_cnt < BIT_RW && sda_s != exp_bit;
   endsequence
   sequence s_wr_byte_end;
      state == ST_WR && scl_fall && bit_cnt == BIT_ACK && !start_cond && !stop_cond;
   endsequence
   sequence s_ack_fall;
      $past(state) == ST_ACK_WR && $past(scl_fall);
   endsequence

   addr_mismatch_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_bad_bit |=> state == ST_IDLE) else $error("mismatch not dropped");
   addr_lsb_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_ADDR && bit_cnt == BIT_A0 && scl_rise && sda_s != addr_lsb && !stop_cond
      && !start_cond |=> state == ST_IDLE) else $error("address LSB not from pin");
   start_det_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_cond && !stop_cond |=> state == ST_ADDR && bit_cnt == 4'h0)
      else $error("start not taken");
   stop_det_a: assert property (@(posedge pclk) disable iff (!presetn)
      stop_cond |=> state == ST_IDLE && !sda_oe) else $error("stop not taken");
   clock_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_IDLE && !start_cond |=> state == ST_IDLE) else $error("gated clock used");
   ack_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_wr_byte_end |=> sda_oe && state == ST_ACK_WR) else $error("no acknowledge");
   open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
      sda_oe |-> state inside {ST_ACK_ADDR, ST_ACK_WR, ST_RD} && sda_o == 1'b0)
      else $error("sda driven outside its slots");
   update_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(channel_a_output) || $changed(channel_b_output) |-> s_ack_fall)
      else $error("register update off the acknowledge edge");
   general_call_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_ADDR && scl_rise && gen_call && !start_cond && !stop_cond
      |=> state == ST_IDLE) else $error("general call answered");
   stage_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      commit && cmd[6] |=> $stable(channel_a_output.code) && $stable(channel_b_output.code))
      else $error("staging write moved output");
endmodule // dacc_top

// [rtl/dacc_pkg.sv]
// shared constants and types of the dual converter control block
package dacc_pkg;
   // ----------------------------------------
   // register map and reset values
   // ----------------------------------------
   localparam int DACC_AW = 12;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_CHAN_A = 12'h004;
   localparam logic [11:0] OFS_CHAN_B = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   localparam logic CTRL_BUS_EN_RESET = 1'b1;
   // ----------------------------------------
   // converter codes and power-down modes
   // ----------------------------------------
   localparam int DACC_CODE_W = 10;
   localparam logic [9:0] CODE_RESET = 10'h000;
   localparam logic [1:0] PD_ON = 2'h0;
   localparam logic [1:0] PD_FLOAT = 2'h1;
   localparam logic [1:0] PD_1K = 2'h2;
   localparam logic [1:0] PD_100K = 2'h3;
   localparam logic [1:0] PD_RESET = PD_100K;
   // ----------------------------------------
   // serial framing
   // ----------------------------------------
   localparam logic [7:0] CMD_EXT = 8'hF0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_RW = 4'h7;
   localparam logic [3:0] BIT_A0 = 4'h6;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WR, ST_ACK_WR, ST_RD, ST_RD_ACK
   } dacc_state_e;

   typedef struct packed {
      logic [DACC_CODE_W-1:0] code;
      logic [1:0] pd;
      logic buf_en;
      logic ref_conn;
      logic term_1k;
      logic term_100k;
   } dacc_chan_s;

   typedef struct packed {
      logic stage_we;
      logic out_we;
      logic pd_we;
      logic [DACC_CODE_W-1:0] data;
      logic [1:0] pd;
   } dacc_wr_s;
endpackage

// [rtl/dacc_sync.sv]
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module dacc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // dacc_sync

// [rtl/dacc_chan.sv]
// one converter channel: staging register, output register, power-down mode
`timescale 1ns/100ps
module dacc_chan
   import dacc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write strobes from the serial side
   input wire dacc_wr_s wr,
   // channel state towards the analog side
   output dacc_chan_s chan
);
   logic [DACC_CODE_W-1:0] stage;
   logic [DACC_CODE_W-1:0] out;
   logic [1:0] pd;
   wire powered = (pd == PD_ON);

   // contents change only on a write strobe, so they persist while powered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage <= CODE_RESET;
         out <= CODE_RESET;
         pd <= PD_RESET;
      end else begin
         if (wr.stage_we) stage <= wr.data;
         if (wr.out_we) out <= wr.stage_we ? wr.data : stage;
         if (wr.pd_we) pd <= wr.pd;
      end
   end

   // straight binary code, buffers and string follow the mode
   assign chan = '{code: out,
                   pd: pd,
                   buf_en: powered,
                   ref_conn: powered,
                   term_1k: (pd == PD_1K),
                   term_100k: (pd == PD_100K)};

   property p_pd_off;
      @(posedge clk) disable iff (!rst_n) (pd != PD_ON) |-> !chan.buf_en && !chan.ref_conn;
   endproperty
   pd_buffers_off_a: assert property (p_pd_off) else $error("buffer on in power-down");
   reset_state_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> out == CODE_RESET && pd == PD_100K && chan.term_100k)
      else $error("bad state after reset");
   wake_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr.pd_we && !wr.out_we |=> $stable(out) && $stable(stage))
      else $error("power-down write changed data");
endmodule // dacc_chan

// [dv/dacc_master.sv]
// two-wire bus master model for the converter control bench
`timescale 1ns/100ps
module dacc_master (
   // bench clock, steps are counted in it
   input wire logic pclk,
   // bus lines
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // ----------------------------------------
   // line steps, a quarter of a 160 ns bus clock each
   // ----------------------------------------
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic q(input int n);
      repeat (n * 4) @(posedge pclk);
   endtask

   // start or repeated start, clock stands high outside frames
   task automatic start;
      if (!scl) begin
         q(1);
         sda_low <= 1'b0;
         q(1);
         scl <= 1'b1;
      end
      q(2);
      sda_low <= 1'b1;
      q(2);
      scl <= 1'b0;
   endtask

   // one bit: data set while the clock is low, held through the high phase
   task automatic bitx(input logic b, output logic r);
      q(1);
      sda_low <= ~b;
      q(1);
      scl <= 1'b1;
      q(1);
      r = sda;
      q(1);
      scl <= 1'b0;
   endtask

   task automatic stop;
      q(1);
      sda_low <= 1'b1;
      q(1);
      scl <= 1'b1;
      q(1);
      sda_low <= 1'b0;
      q(2);
   endtask

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(b[i], r);
      end
      bitx(1'b1, r);
      ack = ~r;
   endtask

   // nack high ends the read
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, d[i]);
      end
      bitx(nack, r);
   endtask
endmodule // dacc_master

// [dv/dacc_top_tb.sv]
// self-checking bench of the dual converter control block
`timescale 1ns/100ps
module dacc_top_tb
   import dacc_pkg::*;
;
   localparam logic [5:0] DEV_HI = 6'h15; // arbitrary upper address bits
   localparam logic [7:0] AW = {DEV_HI, 2'b10};
   localparam logic [7:0] AR = {DEV_HI, 2'b11};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic scl, sda, sda_o, sda_oe, addr_sel, sda_low, e, k;
   logic [7:0] d;
   dacc_chan_s cha, chb;
   int err_total = 0;
   int check_count = 0;

   dacc_top #(.ADDR_HI(DEV_HI)) dacc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .addr_sel(addr_sel), .channel_a_output(cha),
      .channel_b_output(chb));
   dacc_master dacc_master_i (.pclk(pclk), .sda(sda), .scl(scl), .sda_low(sda_low));

   // wired-and data line with pull-up
   assign sda = ((sda_oe && !sda_o) || sda_low) ? 1'b0 : 1'b1;
   always #5 pclk = ~pclk;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   function automatic dacc_chan_s ch(input logic [9:0] c, input logic [1:0] p);
      ch = {c, p, p == 2'h0, p == 2'h0, p == 2'h2, p == 2'h3};
   endfunction

   task automatic chk(input logic [9:0] ac, input logic [1:0] ap, input logic [9:0] bc,
      input logic [1:0] bp);
      cmp(cha, ch(ac, ap), "channel a");
      cmp(chb, ch(bc, bp), "channel b");
   endtask

   task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= we;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         $display("[FAIL] %0t apb answer missing", $time);
         complete_run();
      end
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   function automatic logic [7:0] cmdb(input logic [3:0] c, input logic [9:0] v);
      cmdb = {c, v[9:6]};
   endfunction

   task automatic wframe(input logic [7:0] b1, input logic [7:0] b2);
      dacc_master_i.start();
      dacc_master_i.wbyte(AW, k);
      cmp(k, 1, "address ack");
      dacc_master_i.wbyte(b1, k);
      cmp(k, 1, "first byte ack");
      dacc_master_i.wbyte(b2, k);
      cmp(k, 1, "second byte ack");
      dacc_master_i.stop();
   endtask

   task automatic wr(input logic [3:0] c, input logic [9:0] v);
      wframe(cmdb(c, v), {v[5:0], 2'b00});
   endtask

   task automatic nack_frame(input logic [7:0] a);
      dacc_master_i.start();
      dacc_master_i.wbyte(a, k);
      cmp(k, 0, "address refused");
      dacc_master_i.wbyte(8'h00, k);
      dacc_master_i.wbyte(8'h00, k);
      cmp(k, 0, "clock ignored after refusal");
      dacc_master_i.stop();
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk(10'h000, 2'h3, 10'h000, 2'h3);
      apb(1'b0, OFS_CTRL, 32'h0);
      cmp(rd, 32'h1, "control reset");
      apb(1'b0, OFS_STATUS, 32'h0);
      cmp(rd[1], 1, "address strap");
      apb(1'b1, 12'h010, 32'h1);
      cmp(e, 1, "unmapped write error");
      cmp({sda_oe, sda}, 2'b01, "idle bus");
   endtask

   task automatic t_load_wake;
      logic [1:0] m;
      wr(4'h0, 10'h3FF);
      chk(10'h3FF, 2'h3, 10'h000, 2'h3);
      wframe(8'hF0, 8'h0C);
      chk(10'h3FF, 2'h0, 10'h000, 2'h0);
      for (int p = 1; p <= 4; p++) begin
         m = p[1:0];
         wframe(8'hF0, {4'h0, 2'b01, m});
         chk(10'h3FF, m, 10'h000, 2'h0);
      end
   endtask

   task automatic t_staging;
      wr(4'h4, 10'h155);
      chk(10'h3FF, 2'h0, 10'h000, 2'h0);
      wr(4'h1, 10'h2AA);
      chk(10'h155, 2'h0, 10'h2AA, 2'h0);
   endtask

   task automatic t_refuse;
      nack_frame({DEV_HI, 2'b00});
      nack_frame(8'h00);
      apb(1'b1, OFS_CTRL, 32'h0);
      nack_frame(AW);
      apb(1'b1, OFS_CTRL, 32'h1);
      chk(10'h155, 2'h0, 10'h2AA, 2'h0);
   endtask

   task automatic t_abort_restart;
      dacc_master_i.start();
      dacc_master_i.wbyte(AW, k);
      dacc_master_i.wbyte(cmdb(4'h0, 10'h001), k);
      dacc_master_i.stop();
      chk(10'h155, 2'h0, 10'h2AA, 2'h0);
      dacc_master_i.start();
      dacc_master_i.wbyte(AW, k);
      dacc_master_i.wbyte(cmdb(4'h0, 10'h001), k);
      dacc_master_i.start();
      dacc_master_i.wbyte(AW, k);
      cmp(k, 1, "ack after repeated start");
      dacc_master_i.wbyte(cmdb(4'h0, 10'h0AA), k);
      dacc_master_i.wbyte(8'hA8, k);
      dacc_master_i.stop();
      chk(10'h0AA, 2'h0, 10'h2AA, 2'h0);
   endtask

   task automatic t_read;
      dacc_master_i.start();
      dacc_master_i.wbyte(AR, k);
      cmp(k, 1, "read address ack");
      dacc_master_i.rbyte(1'b0, d);
      cmp(d, 8'h02, "read first byte");
      dacc_master_i.rbyte(1'b1, d);
      cmp(d, 8'hA8, "read second byte");
      dacc_master_i.stop();
      cmp({sda_oe, sda, sda_o}, 3'b010, "bus released");
      apb(1'b0, OFS_CHAN_A, 32'h0);
      cmp(rd, 32'h000000AA, "apb channel a");
      cmp(e, 0, "mapped read error");
      apb(1'b0, OFS_CHAN_B, 32'h0);
      cmp(rd, 32'h000002AA, "apb channel b");
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      addr_sel = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_reset();
      t_load_wake();
      t_staging();
      t_refuse();
      t_abort_restart();
      t_read();
      complete_run();
   end

   initial begin
      repeat (60000) @(posedge pclk);
      err_total++;
      $display("[FAIL] %0t run did not finish", $time);
      complete_run();
   end
endmodule // dacc_top_tb
